// ==== rtl/retrot_pkg.sv ====
package retrot_pkg;
	localparam int data_width = 8;
	localparam int addr_width = 7;
	localparam int pc_width = 13;
	localparam int instr_width = 14;
	localparam int phase_count = 4;
	localparam logic [13:0] return_code = 14'h0008;
	localparam logic [3:0] literal_return_top = 4'hd;
	localparam logic [5:0] rotate_left_top = 6'h0d;
	localparam logic [5:0] rotate_right_top = 6'h0c;
	localparam int dest_bit = 7;
	localparam logic [7:0] accum_reset = 8'h00;
	localparam logic carry_reset = 1'b0;
	localparam logic [12:0] pc_reset = 13'h0000;
	typedef enum logic [3:0] {
		q1 = 4'b0001,
		q2 = 4'b0010,
		q3 = 4'b0100,
		q4 = 4'b1000
	} phase_t;
endpackage : retrot_pkg

// ==== rtl/quarter_phase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module quarter_phase_gen
	import retrot_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	output phase_t phase
);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			phase <= q1;
		else
			unique case (phase)
				q1: phase <= q2;
				q2: phase <= q3;
				q3: phase <= q4;
				q4: phase <= q1;
				default: phase <= q1;
			endcase
	end
endmodule : quarter_phase_gen
`default_nettype wire

// ==== rtl/return_rotate_decoder.sv ====
// Summary of operation
// - literal return loads literal into accumulator, pc from stack top, two cycles.
// - plain return pops stack into program counter, two cycles, no flags.
// - left rotate through carry: old carry to bit 0, bit 7 to carry.
// - destination bit 0 writes accumulator, 1 writes the file register.
// - rotate takes one cycle: decode, read, process, write by quarter phase.
// - only left rotate moves bits upward; one word; only carry changes.
`timescale 1ns/1ps
`default_nettype none
module return_rotate_decoder
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [retrot_pkg::instr_width-1:0] instr,
	input wire logic [retrot_pkg::pc_width-1:0] stack_top_entry,
	input wire logic [retrot_pkg::data_width-1:0] file_rdata,
	output logic [retrot_pkg::addr_width-1:0] file_addr,
	output logic file_read,
	output logic file_write,
	output logic [retrot_pkg::data_width-1:0] file_wdata,
	output logic stack_pop,
	output logic [retrot_pkg::pc_width-1:0] program_counter,
	output logic pc_load,
	output logic [retrot_pkg::data_width-1:0] accum,
	output logic carry,
	output logic flush,
	output logic [3:0] phase_out
);
	import retrot_pkg::*;

	////////////////////////////////////////////////////////////////
	phase_t phase;
	logic [instr_width-1:0] ir;
	logic is_lret, is_ret, is_rl, is_rr, dest_file, nop_cycle;
	logic [data_width-1:0] operand;
	logic [data_width-1:0] next_result;
	logic next_carry;
	logic is_rotate;

	////////////////////////////////////////////////////////////////
	// elaboration guard: the bit slices below are fixed to these sizes
	if (data_width != 8)
	begin : g_data_width_check
		$error("rotate path is wired for an eight-bit file register");
	end
	if (instr_width != 14 || addr_width > dest_bit)
	begin : g_word_layout_check
		$error("address field must sit below the destination bit in a 14-bit word");
	end
	if (phase_count != 4)
	begin : g_phase_count_check
		$error("the sequencer steps through exactly four quarter phases");
	end

	quarter_phase_gen u_phase (
		.clk(clk),
		.reset(reset),
		.phase(phase)
	);

	// decode of the latched word; a flushed cycle decodes nothing
	always_comb
	begin
		is_lret = !nop_cycle && ir[13:10] == literal_return_top;
		is_ret = !nop_cycle && ir == return_code;
		is_rl = !nop_cycle && ir[13:8] == rotate_left_top;
		is_rr = !nop_cycle && ir[13:8] == rotate_right_top;
		is_rotate = is_rl || is_rr;
		dest_file = ir[dest_bit];
	end

	// left goes up, right goes down, carry on the opposite end
	always_comb
	begin
		if (is_rl)
		begin
			next_result = {operand[6:0], carry};
			next_carry = operand[7];
		end
		else
		begin
			next_result = {carry, operand[7:1]};
			next_carry = operand[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// instruction latch; the next word is taken at the close of q4
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ir <= '0;
		else if (phase == q4)
			ir <= instr;
	end

	// the word fetched behind a return is dropped, not executed
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			nop_cycle <= 1'b0;
		else if (phase == q4)
			nop_cycle <= is_lret || is_ret;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			flush <= 1'b0;
		else if (phase == q4)
			flush <= is_lret || is_ret;
	end

	// registered copy keeps the phase pins glitch free
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			phase_out <= 4'h1;
		else
			unique case (phase)
				q1: phase_out <= 4'h2;
				q2: phase_out <= 4'h4;
				q3: phase_out <= 4'h8;
				q4: phase_out <= 4'h1;
			endcase
	end

	////////////////////////////////////////////////////////////////
	// rotate: read in q2, process in q3, write in q4
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			file_read <= 1'b0;
		else
			file_read <= (phase == q1) && is_rotate;
	end

	// address is presented for every word, only the strobes are gated
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			file_addr <= '0;
		else if (phase == q1)
			file_addr <= ir[addr_width-1:0];
	end

	// operand held through q3 so the result is stable for the write
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			operand <= '0;
		else if (phase == q2 && is_rotate)
			operand <= file_rdata;
	end

	// write strobe only when the destination bit picks the file
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			file_write <= 1'b0;
		else
			file_write <= (phase == q3) && is_rotate && dest_file;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			file_wdata <= '0;
		else if (phase == q3)
			file_wdata <= next_result;
	end

	////////////////////////////////////////////////////////////////
	// carry is the only flag touched; returns leave it alone
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			carry <= carry_reset;
		else if (phase == q3 && is_rotate)
			carry <= next_carry;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			accum <= accum_reset;
		else if (phase == q3)
		begin
			if (is_rotate && !dest_file)
				accum <= next_result;
			else if (is_lret)
				accum <= ir[7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// pop at q4 of the first cycle; the stack itself lives outside
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			stack_pop <= 1'b0;
		else
			stack_pop <= (phase == q3) && (is_lret || is_ret);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pc_load <= 1'b0;
		else
			pc_load <= (phase == q3) && (is_lret || is_ret);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			program_counter <= pc_reset;
		else if (phase == q3 && (is_lret || is_ret))
			program_counter <= stack_top_entry;
	end
endmodule : return_rotate_decoder
`default_nettype wire

// ==== dv/retrot_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module retrot_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic [12:0] stack_top_entry,
	input wire logic file_write,
	input wire logic file_read,
	input wire logic stack_pop,
	input wire logic [12:0] program_counter,
	input wire logic pc_load,
	input wire logic carry,
	input wire logic flush,
	input wire logic [3:0] phase_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_wr_q4: assert property (file_write |-> phase_out == 8) else $error("wr");
	chk_pop_q4: assert property (stack_pop |-> pc_load && phase_out == 8) else $error("pop");
	chk_pc_top: assert property (pc_load |-> program_counter == $past(stack_top_entry))
		else $error("pc");
	chk_rd_q2: assert property (file_read |-> phase_out == 2) else $error("rd");
	chk_wr_after_rd: assert property (file_write |-> $past(file_read, 2)) else $error("rw");
	chk_pc_only: assert property ($changed(program_counter) |-> pc_load) else $error("pcx");
	chk_pop_nop: assert property (stack_pop |=> flush) else $error("fl");
	chk_nop_len: assert property ($rose(flush) |-> flush [*4] ##1 !flush) else $error("fn");
	chk_nop_idle: assert property (flush |-> !file_write && !stack_pop) else $error("fi");
	chk_c_q4: assert property ($changed(carry) |-> phase_out == 8) else $error("c");
	cover property (file_write);
	cover property (stack_pop);
	cover property (flush ##1 !flush);
	cover property (file_read ##2 file_write);
endmodule : retrot_asserts
bind return_rotate_decoder retrot_asserts u_chk (.clk, .reset, .stack_top_entry, .file_write,
	.file_read, .stack_pop, .program_counter, .pc_load, .carry, .flush, .phase_out);
`default_nettype wire

// ==== dv/test_return_rotate_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_return_rotate_decoder;
	import retrot_pkg::*;
	logic clk = 0, reset = 1, ec = 0;
	logic [13:0] instr = 0;
	logic [12:0] stack_top_entry = 0, program_counter;
	logic [7:0] file_rdata = 0, ea = 0, file_wdata, accum;
	logic [6:0] file_addr;
	logic [3:0] phase_out;
	logic file_read, file_write, stack_pop, pc_load, carry, flush;
	int errors = 0, num_checks = 0;
	return_rotate_decoder u_return_rotate_decoder (.clk, .reset, .instr, .stack_top_entry,
		.file_rdata, .file_addr, .file_read, .file_write, .file_wdata, .stack_pop,
		.program_counter, .pc_load, .accum, .carry, .flush, .phase_out);
	initial forever #25 clk = ~clk;
	task automatic finish_test;
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic chk(string n, logic [12:0] e, logic [12:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	////////////////////////////////
	// word goes in during Q4, results land four edges later
	task automatic issue(logic [13:0] w);
		repeat (8) if (phase_out !== 4'h8) @(posedge clk) #1;
		if (phase_out !== 4'h8)
		begin
			errors++;
			$display("BAD phase_out exp 8 got %h", phase_out);
			finish_test;
		end
		instr = w;
		repeat (4) @(posedge clk) #1;
	endtask : issue
	task automatic rot(logic l, logic d, logic [6:0] a, logic [7:0] v);
		logic [7:0] r;
		r = l ? {v[6:0], ec} : {ec, v[7:1]};
		file_rdata = v;
		issue({l ? rotate_left_top : rotate_right_top, d, a});
		ec = l ? v[7] : v[0];
		ea = d ? ea : r;
		chk("c", ec, carry);
		chk("w", ea, accum);
		chk("wr", d, file_write);
		if (d) chk("wd", r, file_wdata);
		chk("fa", a, file_addr);
	endtask : rot
	task automatic ret(logic [13:0] w, logic [12:0] t);
		stack_top_entry = t;
		issue(w);
		if (w[13:12] == 2'b11) ea = w[7:0];
		chk("pc", t, program_counter);
		chk("w", ea, accum);
		chk("pop", 1, stack_pop);
		chk("ld", 1, pc_load);
		chk("c", ec, carry);
		// prefetched rotate must be thrown away; executed it would clear carry
		instr = {rotate_left_top, 1'b0, 7'h11};
		file_rdata = 8'h01;
		repeat (4) @(posedge clk) #1;
		chk("nop", 1, flush);
		chk("w2", ea, accum);
		chk("c2", ec, carry);
		chk("pop2", 0, stack_pop);
	endtask : ret
	task automatic rst;
		reset = 1;
		#1;
		chk("rw", accum_reset, accum);
		chk("rc", carry_reset, carry);
		chk("rpc", pc_reset, program_counter);
		chk("rph", 4'h1, phase_out);
		repeat (2) @(posedge clk) #1;
		reset = 0;
		ec = carry_reset;
		ea = accum_reset;
	endtask : rst
	initial
	begin
		repeat (3) @(posedge clk) #1;
		reset = 0;
		rot(1, 0, 7'h05, 8'he6);
		rot(0, 1, 7'h7f, 8'h26);
		rot(1, 1, 7'h00, 8'h80);
		ret({literal_return_top, 2'b10, 8'h5a}, 13'h1abc);
		ret(return_code, 13'h0123);
		rot(0, 0, 7'h40, 8'h01);
		rst;
		rot(1, 0, 7'h2a, 8'h55);
		finish_test;
	end
endmodule : test_return_rotate_decoder
`default_nettype wire
